//--- design/cpu8_alu.sv
/*
  Combinational ALU: two-operand and read/modify/write functions.
  Assumes the decoder picks operands and which flags to keep.
*/
`timescale 1ns/1ns
module cpu8_alu
(
  // Operands and results
  alu_if.calc p
);
  logic [8:0] s9;
  logic [4:0] h5;
  logic       ci;

  always_comb
  begin
    ci = p.cin & ((p.fn == 4'h2) | (p.fn == 4'h9));
    s9 = {1'b0, p.a} - {1'b0, p.b} - {8'h00, ci};
    h5 = {1'b0, p.a[3:0]} + {1'b0, p.b[3:0]} + {4'h0, ci}; // RULE16
    p.r = p.a;
    p.c = s9[8];
    p.h = h5[4];
    if (!p.rmw)
    begin
      unique case (p.fn)
        4'h0, 4'h1, 4'h2, 4'h3: p.r = s9[7:0];
        4'h4, 4'h5: p.r = p.a & p.b;
        4'h6, 4'hE: p.r = p.b;
        4'h8: p.r = p.a ^ p.b;
        4'hA: p.r = p.a | p.b;
        4'h9, 4'hB:
        begin
          s9 = {1'b0, p.a} + {1'b0, p.b} + {8'h00, ci};
          p.r = s9[7:0];
          p.c = s9[8];
        end
        default: p.r = p.a;
      endcase
    end
    else
    begin
      unique case (p.fn) // RULE11
        4'h0:
        begin
          p.r = 8'h00 - p.a;
          p.c = (p.a != 8'h00);
        end
        4'h3:
        begin
          p.r = ~p.a;
          p.c = 1'b1;
        end
        4'h4:
        begin
          p.r = {1'b0, p.a[7:1]};
          p.c = p.a[0];
        end
        4'h6:
        begin
          p.r = {p.cin, p.a[7:1]};
          p.c = p.a[0];
        end
        4'h7:
        begin
          p.r = {p.a[7], p.a[7:1]};
          p.c = p.a[0];
        end
        4'h8:
        begin
          p.r = {p.a[6:0], 1'b0};
          p.c = p.a[7];
        end
        4'h9:
        begin
          p.r = {p.a[6:0], p.cin};
          p.c = p.a[7];
        end
        4'hA: p.r = p.a - 8'h01;
        4'hC: p.r = p.a + 8'h01;
        4'hF: p.r = 8'h00;
        default: p.r = p.a;
      endcase
    end
  end
endmodule : cpu8_alu

//--- design/cpu8_instruction_decode.sv
/*
  8-bit core: fetch, decode and timed execution from its own memory,
  with an Avalon-MM slave for control, state readback and loading.
  Assumes irq_n is asynchronous; software loads memory while halted.
*/
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
`include "cpu8_map.svh"

// What this block does
// (RULE1) Two-operand ops use A or X plus a memory operand; jumps use none
// (RULE2) Arith/load nibble per mode with fixed lengths, cycles; stores +1
// (RULE3) Jump and call opcodes per mode with their own cycle counts
// (RULE4) Relative branches 20-2F, two bytes, three cycles; AD relative call
// (RULE5) Branch conditions come in true/false pairs on flags and pin
// (RULE6) Any bit of the lowest 256 bytes can be set, cleared, tested
// (RULE7) Bit test branches on set or clear, copies bit into carry
// (RULE8) Bit set and clear are one read-modify-write of the byte
// (RULE9) Read/modify/write writes back; the probe only updates flags
// (RULE10) Read/modify/write modes by high nibble with lengths and cycles
// (RULE11) Low nibble picks the unary function; probe is one cycle shorter in memory modes only
// (RULE12) Product of A and X: high byte to X, low to A, clear H and C
// (RULE13) One-byte two-cycle transfers, flag ops, stack reinit and idle
// (RULE14) Soft trap sets mask; stop and wait clear it; subroutine return
// (RULE15) Trap return reloads all flags from the stack
// (RULE16) Half carry only from additions, cleared by product, restored
// (RULE17) Index compare subtracts memory from X without changing X
// (RULE18) Logical compare ANDs with A, sets N and Z, keeps A
// (RULE19) Stack lives in 00C0-00FF and wraps; call 2 bytes, trap 5
// (RULE20) Maskable interrupts stay pending while the mask is set
// (RULE21) Unassigned opcodes act as a one-byte two-cycle idle
// (RULE22) Loads, stores, logic ops set N and Z, keep C and H
module cpu8_instruction_decode
  import cpu8_pkg::*;
#(
  parameter int MEM_AW = 10
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Interrupt pin
  input  wire logic        irq_n,
  // Status
  output logic             core_sleep
);
  logic [7:0]        mem [0:(1<<MEM_AW)-1];
  core_t             q;
  core_t             n;
  logic              mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [7:0]        mem_wd;
  logic              cwe;
  logic [7:0]        op;
  logic [7:0]        b1;
  logic [7:0]        b2;
  logic [3:0]        hi;
  logic [3:0]        lo;
  logic [15:0]       ea;
  logic [7:0]        opnd;
  logic [1:0]        len;
  logic [3:0]        cyc;
  logic              jump_op;
  logic [15:0]       tgt;
  logic [15:0]       rel1;
  logic [15:0]       prod;
  logic              bv;
  logic              cb;
  logic              rmw_ok;
  logic [31:0]       rmux;

  alu_if alu ();

  cpu8_alu u_alu (
    .p (alu)
  );

  function automatic logic [7:0] rd(input logic [15:0] ad);
    return mem[ad[MEM_AW-1:0]];
  endfunction : rd

  function automatic logic [15:0] sa(input logic [5:0] k);
    return {`SP_PAGE, q.sp + k}; // RULE19
  endfunction : sa

  function automatic logic [3:0] mode_cyc(input logic [3:0] h);
    unique case (h) // RULE2
      4'hA: return `CYC_IMM;
      4'hB: return `CYC_DIR;
      4'hC: return `CYC_EXT;
      4'hD: return `CYC_IX2;
      4'hE: return `CYC_IX1;
      default: return `CYC_IX;
    endcase
  endfunction : mode_cyc

  function automatic logic [1:0] mode_len(input logic [3:0] h);
    unique case (h) // RULE2
      4'hC, 4'hD: return 2'h3;
      4'hF: return 2'h1;
      default: return 2'h2;
    endcase
  endfunction : mode_len

  always_comb
  begin
    n = q;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = 8'h00;
    op = rd(q.pc);
    b1 = rd(q.pc + 16'h0001);
    b2 = rd(q.pc + 16'h0002);
    hi = op[7:4];
    lo = op[3:0];
    len = 2'h1;
    cyc = `CYC_INH; // RULE21
    jump_op = 1'b0;
    tgt = 16'h0000;
    bv = 1'b0;
    cb = 1'b0;
    prod = {8'h00, q.a} * {8'h00, q.x};
    rel1 = q.pc + 16'h0002 + {{8{b1[7]}}, b1};
    unique case (hi)
      4'h0, 4'h1, 4'h3, 4'hB: ea = {8'h00, b1}; // RULE6
      4'hC: ea = {b1, b2};
      4'hD: ea = {b1, b2} + {8'h00, q.x};
      4'h6, 4'hE: ea = {8'h00, b1} + {8'h00, q.x};
      4'h7, 4'hF: ea = {8'h00, q.x};
      default: ea = 16'h0000;
    endcase
    opnd = (hi == 4'hA) ? b1 : rd(ea);
    rmw_ok = (lo inside {4'h0, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9,
                         4'hA, 4'hC, 4'hD, 4'hF});
    alu.rmw = (hi inside {[4'h3:4'h7]});
    alu.fn = lo;
    alu.cin = q.f.c;
    alu.b = opnd;
    if (hi == 4'h4)
      alu.a = q.a;
    else if (hi == 4'h5)
      alu.a = q.x;
    else if (hi < 4'h8)
      alu.a = opnd;
    else
      alu.a = (lo == 4'h3 || lo == 4'hF) ? q.x : q.a; // RULE1
    n.s1 = irq_n;
    n.s2 = q.s1;
    n.s3 = q.s2;
    unique case (q.st)
      ST_IDLE:
        if (q.run)
          n.st = ST_VECT;
      ST_VECT:
      begin
        n.pc = {rd(`VEC_RST), rd(`VEC_RST + 16'h0001)};
        n.sp = `SP_TOP;
        n.f.i = 1'b1;
        n.pend = 1'b0;
        n.sleep = 1'b0;
        n.st = ST_EXEC;
      end
      ST_BUSY:
      begin
        if (q.psh_n != 3'h0)
        begin
          mem_we = 1'b1;
          mem_wa = sa(6'h00)[MEM_AW-1:0];
          mem_wd = q.psh[7:0];
          n.psh = {8'h00, q.psh[39:8]};
          n.psh_n = q.psh_n - 3'h1;
          n.sp = q.sp - 6'h01; // RULE19
        end
        n.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1)
          n.st = ST_EXEC;
      end
      ST_EXEC:
        if (!q.run)
          n.st = ST_IDLE;
        else if (q.pend && !q.f.i)
        begin
          n.psh = {3'b111, q.f, q.a, q.x, q.pc};
          n.psh_n = 3'h5;
          n.f.i = 1'b1;
          n.pend = 1'b0;
          n.sleep = 1'b0;
          n.pc = {rd(`VEC_IRQ), rd(`VEC_IRQ + 16'h0001)};
          n.cnt = `CYC_IRQ - 4'h1;
          n.st = ST_BUSY;
        end
        else if (!q.sleep)
        begin
          unique case (hi)
            4'h0:
            begin
              bv = opnd[op[3:1]];
              n.f.c = bv; // RULE7
              len = 2'h3;
              cyc = `CYC_BTB;
              if (bv ^ op[0])
              begin
                jump_op = 1'b1;
                tgt = q.pc + 16'h0003 + {{8{b2[7]}}, b2};
              end
            end
            4'h1:
            begin
              mem_we = 1'b1; // RULE8
              mem_wa = ea[MEM_AW-1:0];
              mem_wd = op[0] ? (opnd & ~(8'h01 << op[3:1]))
                             : (opnd | (8'h01 << op[3:1]));
              len = 2'h2;
              cyc = `CYC_BSC;
            end
            4'h2:
            begin
              unique case (op[3:1]) // RULE5
                3'h0: cb = 1'b1;
                3'h1: cb = ~(q.f.c | q.f.z);
                3'h2: cb = ~q.f.c;
                3'h3: cb = ~q.f.z;
                3'h4: cb = ~q.f.h;
                3'h5: cb = ~q.f.n;
                3'h6: cb = ~q.f.i;
                3'h7: cb = ~q.s2;
              endcase
              len = 2'h2; // RULE4
              cyc = `CYC_REL;
              jump_op = cb ^ op[0];
              tgt = rel1;
            end
            4'h3, 4'h4, 4'h5, 4'h6, 4'h7:
              if (op == 8'h42)
              begin
                n.x = prod[15:8]; // RULE12
                n.a = prod[7:0];
                n.f.h = 1'b0;
                n.f.c = 1'b0;
                cyc = `CYC_MUL;
              end
              else if (rmw_ok)
              begin
                unique case (hi) // RULE10
                  4'h3: cyc = `CYC_RMW_DIR;
                  4'h6: cyc = `CYC_RMW_IX1;
                  4'h7: cyc = `CYC_RMW_IX;
                  default: cyc = `CYC_RMW_REG;
                endcase
                len = (hi == 4'h3 || hi == 4'h6) ? 2'h2 : 2'h1;
                if (lo == 4'hD && hi != 4'h4 && hi != 4'h5)
                  cyc = cyc - `CYC_TST_SUB; // RULE11
                n.f.n = alu.r[7];
                n.f.z = (alu.r == 8'h00);
                if (lo inside {4'h0, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9})
                  n.f.c = alu.c;
                if (lo != 4'hD) // RULE9
                begin
                  if (hi == 4'h4)
                    n.a = alu.r;
                  else if (hi == 4'h5)
                    n.x = alu.r;
                  else
                  begin
                    mem_we = 1'b1;
                    mem_wa = ea[MEM_AW-1:0];
                    mem_wd = alu.r;
                  end
                end
              end
            4'h8, 4'h9:
              unique case (op) // RULE13
                8'h80:
                begin
                  n.f = flags_t'(rd(sa(6'h01))); // RULE15
                  n.a = rd(sa(6'h02));
                  n.x = rd(sa(6'h03));
                  tgt = {rd(sa(6'h04)), rd(sa(6'h05))};
                  jump_op = 1'b1;
                  n.sp = q.sp + 6'h05;
                  cyc = `CYC_RTI;
                end
                8'h81:
                begin
                  tgt = {rd(sa(6'h01)), rd(sa(6'h02))}; // RULE14
                  jump_op = 1'b1;
                  n.sp = q.sp + 6'h02;
                  cyc = `CYC_RTS;
                end
                8'h83:
                begin
                  n.psh = {3'b111, q.f, q.a, q.x, q.pc + 16'h0001};
                  n.psh_n = 3'h5;
                  n.f.i = 1'b1; // RULE14
                  tgt = {rd(`VEC_SWI), rd(`VEC_SWI + 16'h0001)};
                  jump_op = 1'b1;
                  cyc = `CYC_SWI;
                end
                8'h8E, 8'h8F:
                begin
                  n.f.i = 1'b0; // RULE14
                  n.sleep = 1'b1;
                end
                8'h97: n.x = q.a;
                8'h9F: n.a = q.x;
                8'h98: n.f.c = 1'b0;
                8'h99: n.f.c = 1'b1;
                8'h9A: n.f.i = 1'b0;
                8'h9B: n.f.i = 1'b1;
                8'h9C: n.sp = `SP_TOP;
                default: n.a = q.a;
              endcase
            default:
              if (op == 8'hAD)
              begin
                n.psh = {24'h000000, q.pc + 16'h0002}; // RULE4
                n.psh_n = 3'h2;
                jump_op = 1'b1;
                tgt = rel1;
                len = 2'h2;
                cyc = `CYC_BSR;
              end
              else if (!(op inside {8'hA7, 8'hAC, 8'hAF}))
              begin
                len = mode_len(hi);
                cyc = mode_cyc(hi);
                if (lo == 4'hC)
                begin
                  jump_op = 1'b1; // RULE3
                  tgt = ea;
                  cyc = cyc - `CYC_JMP_SUB;
                end
                else if (lo == 4'hD)
                begin
                  n.psh = {24'h000000, q.pc + {14'h0000, len}}; // RULE3
                  n.psh_n = 3'h2;
                  jump_op = 1'b1;
                  tgt = ea;
                  cyc = cyc + `CYC_JSR_ADD;
                end
                else
                begin
                  n.f.n = alu.r[7]; // RULE22
                  n.f.z = (alu.r == 8'h00);
                  if (lo inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'hB})
                    n.f.c = alu.c; // RULE17
                  if (lo == 4'h9 || lo == 4'hB)
                    n.f.h = alu.h; // RULE16
                  if (lo inside {4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'h9,
                                 4'hA, 4'hB})
                    n.a = alu.r; // RULE18
                  else if (lo == 4'hE)
                    n.x = alu.r;
                  else if (lo == 4'h7 || lo == 4'hF)
                  begin
                    mem_we = 1'b1; // RULE2
                    mem_wa = ea[MEM_AW-1:0];
                    mem_wd = alu.r;
                    cyc = cyc + `CYC_ST_ADD;
                  end
                end
              end
          endcase
          n.pc = jump_op ? tgt : q.pc + {14'h0000, len};
          n.cnt = cyc - 4'h1;
          n.st = ST_BUSY;
        end
    endcase
    cwe = mem_we;
    unique case (avs_address)
      `REG_CTRL: rmux = {31'h00000000, q.run};
      `REG_CORE: rmux = {6'h00, q.pend, q.sleep, 3'h0, q.f, q.x, q.a};
      `REG_PCSP: rmux = {10'h000, q.sp, q.pc};
      `REG_MADR: rmux = {16'h0000, q.mptr};
      `REG_MDAT: rmux = {24'h000000, rd(q.mptr)};
      default: rmux = 32'h00000000;
    endcase
    n.rd_ack = avs_read & ~q.rd_ack;
    if (avs_read && !q.rd_ack)
      n.rdata = rmux;
    if (avs_read && q.rd_ack && avs_address == `REG_MDAT)
      n.mptr = q.mptr + 16'h0001;
    if (avs_write)
    begin
      unique case (avs_address)
        `REG_CTRL: n.run = avs_writedata[`CTRL_RUN];
        `REG_MADR: n.mptr = avs_writedata[15:0];
        `REG_MDAT:
          if (!cwe)
          begin
            mem_we = 1'b1;
            mem_wa = q.mptr[MEM_AW-1:0];
            mem_wd = avs_writedata[7:0];
            n.mptr = q.mptr + 16'h0001;
          end
        default: n.run = q.run;
      endcase
    end
    if (q.s3 && !q.s2)
      n.pend = 1'b1; // RULE20
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.st <= ST_IDLE;
    end
    else
      q <= n;
  end

  always_ff @(posedge clk)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end

  assign avs_readdata = q.rdata;
  assign avs_waitrequest = (avs_read & ~q.rd_ack)
                         | (avs_write & cwe & (avs_address == `REG_MDAT));
  assign core_sleep = q.sleep;
endmodule : cpu8_instruction_decode

//--- shared/alu_if.sv
/*
  Operand and result bundle between the decoder and its ALU.
  Assumes one driver on each side.
*/
`timescale 1ns/1ns
interface alu_if;
  logic       rmw;
  logic [3:0] fn;
  logic [7:0] a;
  logic [7:0] b;
  logic       cin;
  logic [7:0] r;
  logic       c;
  logic       h;
  modport calc (input rmw, fn, a, b, cin, output r, c, h);
  modport user (output rmw, fn, a, b, cin, input r, c, h);
endinterface : alu_if

//--- shared/cpu8_map.svh
/*
  Register offsets, vectors, stack page and cycle counts of the core.
  Assumes inclusion by bare name from files that need the constants.
*/
`ifndef CPU8_MAP_SVH
`define CPU8_MAP_SVH
// Avalon byte offsets
`define REG_CTRL    5'h00
`define REG_CORE    5'h04
`define REG_PCSP    5'h08
`define REG_MADR    5'h0C
`define REG_MDAT    5'h10
`define CTRL_RUN    0
// Stack and vectors
`define SP_TOP      6'h3F
`define SP_PAGE     10'h003
`define VEC_RST     16'hFFFE
`define VEC_SWI     16'hFFFC
`define VEC_IRQ     16'hFFFA
// Cycle counts
`define CYC_INH     4'h2
`define CYC_REL     4'h3
`define CYC_BSR     4'h6
`define CYC_BTB     4'h5
`define CYC_BSC     4'h5
`define CYC_MUL     4'hB
`define CYC_SWI     4'hA
`define CYC_IRQ     4'hA
`define CYC_RTI     4'h9
`define CYC_RTS     4'h6
`define CYC_IMM     4'h2
`define CYC_DIR     4'h3
`define CYC_EXT     4'h4
`define CYC_IX2     4'h5
`define CYC_IX1     4'h4
`define CYC_IX      4'h3
`define CYC_ST_ADD  4'h1
`define CYC_JMP_SUB 4'h1
`define CYC_JSR_ADD 4'h2
`define CYC_RMW_REG 4'h3
`define CYC_RMW_DIR 4'h5
`define CYC_RMW_IX  4'h5
`define CYC_RMW_IX1 4'h6
`define CYC_TST_SUB 4'h1
`endif

//--- shared/cpu8_pkg.sv
/*
  Types of the 8-bit core: state codes, flag set and full core state.
  Assumes nothing of its surroundings.
*/
package cpu8_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_VECT = 4'b0010,
    ST_EXEC = 4'b0100,
    ST_BUSY = 4'b1000
  } cpu_state_t;

  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } flags_t;

  typedef struct packed {
    cpu_state_t  st;
    logic [7:0]  a;
    logic [7:0]  x;
    flags_t      f;
    logic [15:0] pc;
    logic [5:0]  sp;
    logic [3:0]  cnt;
    logic [2:0]  psh_n;
    logic [39:0] psh;
    logic        pend;
    logic        sleep;
    logic        run;
    logic        s1;
    logic        s2;
    logic        s3;
    logic        rd_ack;
    logic [31:0] rdata;
    logic [15:0] mptr;
  } core_t;
endpackage : cpu8_pkg

//--- test/cpu8_instruction_decode_chk.sv
/*
  Port checker of the 8-bit core: bus answers, readback and sleep.
  Assumes it is bound to the core's top module and sees its ports.
*/
`timescale 1ns/1ns
module cpu8_decode_chk
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Avalon-MM slave
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Pin and status
  input wire logic        irq_n,
  input wire logic        core_sleep
);
  logic run_ff;
  logic rd_ok;
  logic mapped;

  assign rd_ok  = avs_read && !avs_waitrequest;
  assign mapped = avs_address inside {5'h00, 5'h04, 5'h08, 5'h0C, 5'h10};

  // Last run bit written
  always_ff @(posedge clk)
    if (sys_rst)
      run_ff <= 1'h0;
    else if (avs_write && !avs_waitrequest && avs_address == 5'h00)
      run_ff <= avs_writedata[0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_read_waits: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read answered without a wait cycle");
  a_read_answer: assert property (avs_read && avs_waitrequest |=>
    !avs_waitrequest) else $error("read not answered after one wait");
  a_write_prompt: assert property (avs_write && avs_address != 5'h10
    |-> !avs_waitrequest) else $error("register write stalled");
  a_mdat_bound: assert property (avs_write && avs_address == 5'h10
    |-> ##[0:5] !avs_waitrequest) else $error("memory write stall too long");
  a_unmapped_zero: assert property (rd_ok && !mapped |->
    avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_data_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  a_run_readback: assert property (rd_ok && avs_address == 5'h00 |->
    avs_readdata[0] == run_ff) else $error("run bit readback wrong");
  a_sleep_wake: assert property ($fell(irq_n) && core_sleep |->
    ##[1:20] !core_sleep) else $error("sleep not left on interrupt");
  a_sleep_reset: assert property ($fell(sys_rst) |-> !core_sleep)
    else $error("sleep set after reset");

  cover property (rd_ok && avs_address == 5'h04);
  cover property ($rose(core_sleep));
  cover property (avs_write && avs_address == 5'h10 && avs_waitrequest);
endmodule : cpu8_decode_chk

bind cpu8_instruction_decode cpu8_decode_chk cpu8_decode_chk_i
(
  .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq_n(irq_n),
  .core_sleep(core_sleep)
);

//--- test/cpu8_instruction_decode_tb.sv
/*
  Self-checking bench of the 8-bit core: loads programs over the bus,
  runs them, halts and compares register readback.
  Assumes the core, its package and the bound checker are compiled.
*/
`timescale 1ns/1ns
`define CHECK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("ERROR at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module cpu8_instruction_decode_tb;
  typedef struct packed {
    logic [95:0] p;
    logic [3:0]  n;
    logic [7:0]  a;
    logic [7:0]  x;
    logic [4:0]  f;
  } row_t;

  logic        clk;
  logic        sys_rst;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq_n;
  logic        core_sleep;
  logic [31:0] d;
  int          mismatches = 0;
  int          total_checks = 0;
  // Program, length, expected A, X and flags H,I,N,Z,C
  row_t        rows [16] = '{
    '{96'hA680, 4'h2, 8'h80, 8'h00, 5'h0C},
    '{96'hA610AE2042, 4'h5, 8'h00, 8'h02, 5'h08},
    '{96'hA6059799, 4'h4, 8'h05, 8'h05, 5'h09},
    '{96'hA60FAB01, 4'h4, 8'h10, 8'h00, 5'h18},
    '{96'hA600AE05A306, 4'h6, 8'h00, 8'h05, 5'h0D},
    '{96'hA6F0A50F, 4'h4, 8'hF0, 8'h00, 5'h0A},
    '{96'hA68148, 4'h3, 8'h02, 8'h00, 5'h09},
    '{96'hA60140, 4'h3, 8'hFF, 8'h00, 5'h0D},
    '{96'hA6805D, 4'h3, 8'h80, 8'h00, 5'h0A},
    '{96'h3F501450045002A633B650, 4'hB, 8'h04, 8'h00, 5'h09},
    '{96'hA60026022702A611, 4'h8, 8'h00, 8'h00, 5'h0A},
    '{96'hCC0108A611A622, 4'h7, 8'h22, 8'h00, 5'h08},
    '{96'hA6019A, 4'h3, 8'h01, 8'h00, 5'h00},
    '{96'hA60182, 4'h3, 8'h01, 8'h00, 5'h08},
    '{96'hA67FB7603C60B660, 4'h8, 8'h80, 8'h00, 5'h0C},
    '{96'hAD04A64420FEAE5581, 4'h9, 8'h44, 8'h55, 5'h08}};

  cpu8_instruction_decode #(.MEM_AW(10)) cpu8_instruction_decode_i
  (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_n(irq_n),
    .core_sleep(core_sleep)
  );

  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] ad,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    avs_address   <= ad;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'h0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 100)
      mismatches++;
    rd = avs_readdata;
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [4:0] ad, input logic [31:0] wd);
    bus(1'h1, ad, wd, d);
  endtask : wr

  // Loads prefix, program and a closing self loop at 0x0100, then runs
  task automatic run_prog(input logic [95:0] p, input logic [3:0] n,
                          input logic halt);
    logic [7:0] q[$];
    q = '{8'h42, 8'hAE, 8'h00};
    for (int i = 0; i < n; i++)
      q.push_back(p[8 * (n - 1 - i) +: 8]);
    q.push_back(8'h20);
    q.push_back(8'hFE);
    wr(5'h00, 32'h0);
    wr(5'h0C, 32'h0100);
    foreach (q[i])
      wr(5'h10, {24'h0, q[i]});
    wr(5'h00, 32'h1);
    repeat (150) @(posedge clk);
    if (halt)
      wr(5'h00, 32'h0);
    repeat (20) @(posedge clk);
    bus(1'h0, 5'h04, 32'h0, d);
  endtask : run_prog

  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial
  begin
    sys_rst       = 1'h1;
    avs_address   = 5'h00;
    avs_read      = 1'h0;
    avs_write     = 1'h0;
    avs_writedata = 32'h0;
    irq_n         = 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    bus(1'h0, 5'h04, 32'h0, d);
    `CHECK(d[24], 1'h0)
    wr(5'h18, 32'hFF);
    bus(1'h0, 5'h18, 32'h0, d);
    `CHECK(d, 32'h0)
    // Reset and interrupt vectors, interrupt handler loop
    wr(5'h0C, 32'hFFFE);
    wr(5'h10, 32'h01);
    wr(5'h10, 32'h00);
    wr(5'h0C, 32'hFFFA);
    wr(5'h10, 32'h01);
    wr(5'h10, 32'h20);
    wr(5'h0C, 32'h0120);
    wr(5'h10, 32'h20);
    wr(5'h10, 32'hFE);
    foreach (rows[i])
    begin
      run_prog(rows[i].p, rows[i].n, 1'h1);
      `CHECK(d[15:0], {rows[i].x, rows[i].a})
      `CHECK(d[24:16], {4'h0, rows[i].f})
    end
    // Stop, then wake by the pin
    run_prog(96'hA6018E, 4'h3, 1'h0);
    `CHECK({d[24], d[19]}, 2'h2)
    irq_n <= 1'h0;
    repeat (4) @(posedge clk);
    irq_n <= 1'h1;
    repeat (60) @(posedge clk);
    wr(5'h00, 32'h0);
    repeat (20) @(posedge clk);
    bus(1'h0, 5'h04, 32'h0, d);
    `CHECK({d[24], d[19]}, 2'h1)
    bus(1'h0, 5'h08, 32'h0, d);
    `CHECK(d[21:0], {6'h3A, 16'h0120})
    // Second reset while asleep
    wr(5'h00, 32'h1);
    repeat (50) @(posedge clk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    bus(1'h0, 5'h04, 32'h0, d);
    `CHECK(d[24], 1'h0)
    tally_and_finish();
  end
endmodule : cpu8_instruction_decode_tb
